// ==== status_monitor_defines.svh ====
/*
 Holds the register offsets, field positions, reset values and thresholds of the drive
 status and monitor display block as macros. Assumes inclusion by bare name.
*/
`ifndef STATUS_MONITOR_DEFINES_SVH
`define STATUS_MONITOR_DEFINES_SVH

// ==========================================================================
// Register byte offsets (one aligned 32-bit word each).
// ==========================================================================
`define REG_SETUP_FIRST      8'h00
`define REG_SETUP_SECOND     8'h04
`define REG_ROT_DETECT       8'h08
`define REG_KEYS             8'h0c
`define REG_DISPLAY          8'h10
`define REG_MONITOR_DATA     8'h14
`define REG_STATUS_BITS      8'h18

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define SETUP_FIRST_DETECT_SEL 4
`define SETUP_SECOND_REV_DIR   0
`define KEY_MODE_BIT           0
`define KEY_DATA_BIT           1
`define KEY_UP_BIT             2
`define KEY_DOWN_BIT           3
`define SETUP_RESET            16'h0000
`define ROT_DETECT_RESET       16'h0014
`define MONITOR_NUMBER_MAX     3'h5

// ==========================================================================
// Scaling: rated torque reads 100 percent, ten percent is the input threshold.
// ==========================================================================
`define TORQUE_INPUT_PERCENT   16'h000a

`endif

// ==== status_monitor_pkg.sv ====
/*
 Holds the types of the drive status and monitor display block.
 Assumes nothing of its surroundings.
*/
package status_monitor_pkg;

   // ========================================================================
   // Display modes, one-hot, in the order the mode key steps through them.
   // ========================================================================
   typedef enum logic [3:0]
   {
      mode_status   = 4'b0001,
      mode_settings = 4'b0010,
      mode_monitor  = 4'b0100,
      mode_alarm    = 4'b1000
   } display_mode_type;

   // Symbol codes shown by the three-digit symbol display.
   typedef enum logic [2:0]
   {
      sym_unpowered = 3'h0,
      sym_run       = 3'h1,
      sym_fwd_proh  = 3'h2,
      sym_rev_proh  = 3'h3,
      sym_alarm     = 3'h4
   } symbol_type;

endpackage

// ==== key_edge.sv ====
/*
 Synchronises a group of key pins with two flip-flops and gives a one-cycle
 press pulse on each rising edge. Assumes keys are already debounced outside.
*/
`timescale 1ns/10ps

module key_edge
#(
   parameter int WIDTH = 4
)
(
   // Clock and reset.
   input  wire logic             i_clock,
   input  wire logic             i_rst_b,
   // Keys and presses.
   input  wire logic [WIDTH-1:0] i_keys,
   output logic      [WIDTH-1:0] o_press
);

   logic [WIDTH-1:0] sync_first;
   logic [WIDTH-1:0] sync_second;
   logic [WIDTH-1:0] sync_last;

   // Only the second stage feeds the edge detector, to keep metastability out.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sync_first  <= '0;
         sync_second <= '0;
         sync_last   <= '0;
         o_press     <= '0;
      end
      else
      begin
         sync_first  <= i_keys;
         sync_second <= sync_first;
         sync_last   <= sync_second;
         o_press     <= sync_second & ~sync_last;
      end
   end

endmodule

// ==== drive_status_monitor_display.sv ====
/*
 Status and monitor presentation logic of a servo drive: display mode cycling,
 status indicators, status symbol, internal status word and monitor selection,
 with settings reached over a classic Wishbone slave. Assumes quantities arrive
 already scaled (speed in r/min, torque in percent of rated, angle in degrees,
 pulses in encoder units) from logic on the same clock, and pins from outside.
*/
`timescale 1ns/10ps
`include "status_monitor_defines.svh"

module drive_status_monitor_display
(
   // Clock and reset.
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   // Wishbone classic slave.
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // Parameter unit keys: mode/set, data, up, down.
   input  wire logic [3:0]  i_keys,
   // Drive quantities on this clock.
   input  wire logic [15:0] i_speed_feedback,
   input  wire logic [15:0] i_speed_command,
   input  wire logic [15:0] i_torque_command,
   input  wire logic [15:0] i_u_phase_pulses,
   input  wire logic [15:0] i_electrical_angle,
   input  wire logic        i_speed_conform,
   input  wire logic        i_torque_clamped,
   input  wire logic        i_alarm_active,
   input  wire logic [7:0]  i_alarm_code,
   input  wire logic        i_dyn_brake_on,
   input  wire logic        i_prop_ctrl_active,
   input  wire logic        i_motor_powered,
   input  wire logic        i_encoder_inverted,
   // Pins from outside: limits, encoder A B Z, poles U V W, run, multi, prohibits, sensor.
   input  wire logic [12:0] i_pins,
   // Display outputs.
   output status_monitor_pkg::display_mode_type o_mode,
   output status_monitor_pkg::symbol_type       o_symbol,
   output logic [7:0]       o_symbol_alarm,
   output logic             o_led_power,
   output logic             o_led_unpowered_full,
   output logic             o_led_unpowered_dim,
   output logic             o_led_speed_conform,
   output logic             o_led_shared_detect,
   output logic             o_led_speed_input,
   output logic             o_led_torque_input,
   output logic [2:0]       o_monitor_number,
   output logic             o_show_data,
   output logic [20:0]      o_status_bits
);

   // =======================================================================
   // Declarations.
   // =======================================================================
   logic [15:0] setup_param_first;
   logic [15:0] setup_param_second;
   logic [15:0] rotation_detect_speed;
   logic [3:0]  key_press;
   logic [3:0]  soft_keys;
   logic [12:0] pin_sync_first;
   logic [12:0] pins;
   logic [15:0] monitor_data;
   status_monitor_pkg::display_mode_type mode;
   status_monitor_pkg::display_mode_type next_mode;
   logic [2:0]  monitor_number;
   logic        show_data;

   // Absolute value helper used for every magnitude comparison.
   function automatic logic [15:0] magnitude(input logic [15:0] value);
      magnitude = value[15] ? 16'(-value) : value;
   endfunction

   // =======================================================================
   // Pin synchroniser and key edges.
   // =======================================================================
   // Two stages; only the second is read by any logic.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pin_sync_first <= '0;
         pins           <= '0;
      end
      else
      begin
         pin_sync_first <= i_pins;
         pins           <= pin_sync_first;
      end
   end

   key_edge #(.WIDTH(4)) u_keys
   (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_keys  (i_keys),
      .o_press (key_press)
   );

   // Software key presses are merged so a bus master can drive the panel too.
   wire [3:0] press = key_press | soft_keys;

   // =======================================================================
   // Derived indications.
   // =======================================================================
   wire detect_sel     = setup_param_first[`SETUP_FIRST_DETECT_SEL];
   wire rotation_det   = magnitude(i_speed_feedback) >= rotation_detect_speed;
   wire shared_detect_out = detect_sel ? i_torque_clamped : rotation_det;
   wire speed_input    = magnitude(i_speed_command) >= rotation_detect_speed;
   wire torque_input   = magnitude(i_torque_command) >= `TORQUE_INPUT_PERCENT;
   wire rev_dir        = setup_param_second[`SETUP_SECOND_REV_DIR];

   // Encoder phases follow the model family polarity.
   wire [2:0] enc_phases = pins[4:2] ^ {3{i_encoder_inverted}};

   // Bit 0 is unused and reads zero.
   wire [20:0] next_status_bits = {pins[12], pins[11:10], pins[9], pins[8],
                                   pins[7:5], enc_phases,
                                   i_motor_powered, pins[1], pins[0],
                                   i_prop_ctrl_active, i_speed_conform,
                                   shared_detect_out, rev_dir,
                                   i_dyn_brake_on, i_alarm_active, 1'b0};

   // Symbol priority: alarm, then prohibits, then unpowered, else run.
   wire [2:0] next_symbol =
      i_alarm_active   ? 3'(status_monitor_pkg::sym_alarm)     :
      pins[10]         ? 3'(status_monitor_pkg::sym_fwd_proh)  :
      pins[11]         ? 3'(status_monitor_pkg::sym_rev_proh)  :
      !i_motor_powered ? 3'(status_monitor_pkg::sym_unpowered) :
                         3'(status_monitor_pkg::sym_run);

   // Monitor select; quantities pass live so the data refreshes each cycle.
   wire [15:0] next_monitor_data =
      (monitor_number == 3'h0) ? i_speed_feedback   :
      (monitor_number == 3'h1) ? i_speed_command    :
      (monitor_number == 3'h2) ? i_torque_command   :
      (monitor_number == 3'h3) ? i_u_phase_pulses   :
      (monitor_number == 3'h4) ? i_electrical_angle :
                                 {11'h000, next_status_bits[5:1]};

   // =======================================================================
   // Mode cycle.
   // =======================================================================
   always_comb
   begin
      next_mode = mode;
      if (press[`KEY_MODE_BIT])
      begin
         case (mode)
            status_monitor_pkg::mode_status:   next_mode = status_monitor_pkg::mode_settings;
            status_monitor_pkg::mode_settings: next_mode = status_monitor_pkg::mode_monitor;
            status_monitor_pkg::mode_monitor:  next_mode = status_monitor_pkg::mode_alarm;
            status_monitor_pkg::mode_alarm:    next_mode = status_monitor_pkg::mode_status;
            default:                           next_mode = status_monitor_pkg::mode_status;
         endcase
      end
   end

   // Reset enters status display mode.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         mode <= status_monitor_pkg::mode_status;
      else
         mode <= next_mode;
   end

   // Monitor number and data toggle; leaving monitor mode drops to number view.
   wire in_monitor = (mode == status_monitor_pkg::mode_monitor);
   wire num_up     = in_monitor && !show_data && press[`KEY_UP_BIT] &&
                     (monitor_number != `MONITOR_NUMBER_MAX);
   wire num_down   = in_monitor && !show_data && press[`KEY_DOWN_BIT] &&
                     (monitor_number != 3'h0);
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         monitor_number <= 3'h0;
         show_data      <= 1'b0;
      end
      else
      begin
         if (num_up)
            monitor_number <= monitor_number + 3'h1;
         else if (num_down)
            monitor_number <= monitor_number - 3'h1;
         if (!in_monitor || press[`KEY_MODE_BIT])
            show_data <= 1'b0;
         else if (press[`KEY_DATA_BIT])
            show_data <= !show_data;
      end
   end

   // =======================================================================
   // Display outputs, all registered.
   // =======================================================================
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_symbol             <= status_monitor_pkg::sym_unpowered;
         o_symbol_alarm       <= 8'h00;
         o_led_power          <= 1'b0;
         o_led_unpowered_full <= 1'b0;
         o_led_unpowered_dim  <= 1'b0;
         o_led_speed_conform  <= 1'b0;
         o_led_shared_detect  <= 1'b0;
         o_led_speed_input    <= 1'b0;
         o_led_torque_input   <= 1'b0;
         o_status_bits        <= '0;
         monitor_data         <= 16'h0000;
      end
      else
      begin
         o_symbol             <= status_monitor_pkg::symbol_type'(next_symbol);
         o_symbol_alarm       <= i_alarm_active ? i_alarm_code : 8'h00;
         o_led_power          <= 1'b1;
         o_led_unpowered_full <= !i_motor_powered;
         o_led_unpowered_dim  <= i_motor_powered;
         o_led_speed_conform  <= i_speed_conform;
         o_led_shared_detect  <= shared_detect_out;
         o_led_speed_input    <= speed_input;
         o_led_torque_input   <= torque_input;
         o_status_bits        <= next_status_bits;
         monitor_data         <= (monitor_number == 3'h5) ?
                                 next_status_bits[16:1] : next_monitor_data;
      end
   end

   assign o_mode           = mode;
   assign o_monitor_number = monitor_number;
   assign o_show_data      = show_data;

   // =======================================================================
   // Wishbone slave: one wait state, ack lasts one cycle.
   // =======================================================================
   wire wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire wb_write = wb_req && i_wb_we && i_wb_sel[0];
   wire [31:0] rd_word =
      (i_wb_adr == `REG_SETUP_FIRST)  ? {16'h0000, setup_param_first}     :
      (i_wb_adr == `REG_SETUP_SECOND) ? {16'h0000, setup_param_second}    :
      (i_wb_adr == `REG_ROT_DETECT)   ? {16'h0000, rotation_detect_speed} :
      (i_wb_adr == `REG_DISPLAY)      ? {24'h000000, show_data, monitor_number, mode} :
      (i_wb_adr == `REG_MONITOR_DATA) ? {16'h0000, monitor_data}          :
      (i_wb_adr == `REG_STATUS_BITS)  ? {11'h000, o_status_bits}          :
                                        32'h00000000;

   // Byte lanes 0 and 1 carry the 16-bit setup fields.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         setup_param_first     <= `SETUP_RESET;
         setup_param_second    <= `SETUP_RESET;
         rotation_detect_speed <= `ROT_DETECT_RESET;
         soft_keys             <= 4'h0;
         o_wb_ack              <= 1'b0;
         o_wb_dat              <= 32'h00000000;
      end
      else
      begin
         o_wb_ack  <= wb_req;
         o_wb_dat  <= wb_req ? rd_word : 32'h00000000;
         soft_keys <= 4'h0;
         if (wb_write && i_wb_adr == `REG_SETUP_FIRST)
            setup_param_first[7:0] <= i_wb_dat[7:0];
         if (wb_write && i_wb_adr == `REG_SETUP_SECOND)
            setup_param_second[7:0] <= i_wb_dat[7:0];
         if (wb_write && i_wb_adr == `REG_ROT_DETECT)
            rotation_detect_speed[7:0] <= i_wb_dat[7:0];
         if (wb_write && i_wb_adr == `REG_KEYS)
            soft_keys <= i_wb_dat[3:0];
         if (wb_req && i_wb_we && i_wb_sel[1] && i_wb_adr == `REG_SETUP_FIRST)
            setup_param_first[15:8] <= i_wb_dat[15:8];
         if (wb_req && i_wb_we && i_wb_sel[1] && i_wb_adr == `REG_SETUP_SECOND)
            setup_param_second[15:8] <= i_wb_dat[15:8];
         if (wb_req && i_wb_we && i_wb_sel[1] && i_wb_adr == `REG_ROT_DETECT)
            rotation_detect_speed[15:8] <= i_wb_dat[15:8];
      end
   end

   // =======================================================================
   // Assertions.
   // =======================================================================
   AST_RESET_STATUS_MODE: assert property (@(posedge i_clock)
      $rose(i_rst_b) |-> mode == status_monitor_pkg::mode_status)
      else $error("Mode after reset is not status display.");
   AST_MODE_ADVANCE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      press[`KEY_MODE_BIT] && mode == status_monitor_pkg::mode_alarm
      |=> mode == status_monitor_pkg::mode_status)
      else $error("Mode key did not wrap to status display.");
   AST_UNPOWERED_LED: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_rst_b |=> o_led_unpowered_full == !$past(i_motor_powered))
      else $error("Unpowered indicator does not follow motor power.");
   AST_CONFORM_BIT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_speed_conform |=> o_status_bits[5] && o_led_speed_conform)
      else $error("Speed conformity not shown.");
   AST_DETECT_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      detect_sel && i_torque_clamped |=> o_led_shared_detect && o_status_bits[4])
      else $error("Current limit detection not shown.");
   AST_ROT_DETECT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      !detect_sel && !rotation_det |=> !o_led_shared_detect)
      else $error("Rotation detection lit below threshold.");
   AST_TORQUE_INPUT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_torque_command == 16'h0009 |=> !o_led_torque_input)
      else $error("Torque input lit below ten percent.");
   AST_ALARM_SYMBOL: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      i_alarm_active |=> o_symbol == status_monitor_pkg::sym_alarm)
      else $error("Alarm symbol lost priority.");
   AST_DATA_TOGGLE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      in_monitor && press[`KEY_DATA_BIT] && !press[`KEY_MODE_BIT] |=> show_data != $past(show_data))
      else $error("Data key did not toggle.");
   AST_REV_DIR: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      ##1 o_status_bits[3] == $past(rev_dir))
      else $error("Reverse direction bit wrong.");

   COV_MONITOR_DATA: cover property (@(posedge i_clock) disable iff (!i_rst_b)
      in_monitor && show_data);
   COV_RUN_SYMBOL: cover property (@(posedge i_clock) disable iff (!i_rst_b)
      o_symbol == status_monitor_pkg::sym_run);
   COV_BUS_WRITE: cover property (@(posedge i_clock) disable iff (!i_rst_b)
      wb_write ##1 o_wb_ack);

endmodule

// ==== param_unit_model.sv ====
/*
 Behavioural parameter unit: presses the mode, data, up and down keys on request.
 Assumes the bench clock; key pins are plain high-active levels, already debounced.
*/
`timescale 1ns/10ps

module param_unit_model
(
   // Clock in, key pins out.
   input  wire logic       i_clock,
   output logic      [3:0] o_keys
);
   // Keys start released so no press is seen straight after reset.
   initial o_keys = 4'h0;

   // One press: held for hold cycles, then released long enough for the next press.
   task automatic press(input int idx, input int hold);
      @(posedge i_clock);
      o_keys[idx] <= 1'b1;
      repeat (hold) @(posedge i_clock);
      o_keys[idx] <= 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
   endtask
endmodule

// ==== drive_status_monitor_display_tb.sv ====
/*
 Self-checking bench of the status and monitor display block.
 Assumes the parameter unit model drives the keys and a 125 MHz clock.
*/
`timescale 1ns/10ps
`include "status_monitor_defines.svh"

module drive_status_monitor_display_tb;
   // ======================================================================
   // Stimulus and observed signals.
   // ======================================================================
   logic clock, rst_b, cyc, stb, we, ack, conform, clamped, alarm, dyn_brake_on, prop, powered, inv;
   logic led_pwr, led_full, led_dim, led_conf, led_det, led_spd, led_trq, show, rev;
   logic [7:0] adr, acode, sym_code;
   logic [3:0] sel, keys;
   logic [31:0] wdat, rdat, rd;
   logic [15:0] spd_fb, spd_cmd, trq, pulses, angle;
   logic [12:0] pins;
   logic [2:0] mon_num;
   logic [20:0] sbits;
   status_monitor_pkg::display_mode_type mode;
   status_monitor_pkg::symbol_type symbol;
   int err_total, n_tests;

   always #4 clock = ~clock;

   param_unit_model i_pu (.i_clock(clock), .o_keys(keys));

   drive_status_monitor_display i_dut (.i_clock(clock), .i_rst_b(rst_b), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_keys(keys), .i_speed_feedback(spd_fb),
      .i_speed_command(spd_cmd), .i_torque_command(trq), .i_u_phase_pulses(pulses),
      .i_electrical_angle(angle), .i_speed_conform(conform), .i_torque_clamped(clamped),
      .i_alarm_active(alarm), .i_alarm_code(acode), .i_dyn_brake_on(dyn_brake_on),
      .i_prop_ctrl_active(prop), .i_motor_powered(powered), .i_encoder_inverted(inv),
      .i_pins(pins), .o_mode(mode), .o_symbol(symbol), .o_symbol_alarm(sym_code),
      .o_led_power(led_pwr), .o_led_unpowered_full(led_full), .o_led_unpowered_dim(led_dim),
      .o_led_speed_conform(led_conf), .o_led_shared_detect(led_det),
      .o_led_speed_input(led_spd), .o_led_torque_input(led_trq), .o_monitor_number(mon_num),
      .o_show_data(show), .o_status_bits(sbits));

   // ======================================================================
   // Shared tasks.
   // ======================================================================
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic cycle; ack and read data are taken at the rising edge where ack is high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clock);
         if (ack === 1'b1) break;
      end
      if (k == 50)
      begin
         err_total++;
         tally_and_finish();
      end
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   // Registered outputs trail the pins by the two sync stages plus one.
   task automatic settle();
      repeat (4) @(posedge clock);
      #1;
   endtask

   function automatic logic [20:0] exp_bits();
      return {pins[12:5], pins[4:2] ^ {3{inv}}, powered, pins[1:0], prop, conform,
              clamped, rev, dyn_brake_on, alarm, 1'b0};
   endfunction

   // ======================================================================
   // Scenarios.
   // ======================================================================
   task automatic t_modes();
      chk(mode, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         i_pu.press(0, 2);
         chk(mode, 32'h1 << ((i + 1) % 4));
      end
   endtask

   task automatic t_leds();
      @(posedge clock); conform <= 1'b1;
      settle();
      chk({led_pwr, led_full, led_dim, led_conf, sbits[5]}, 32'h1b);
      @(posedge clock); powered <= 1'b1; conform <= 1'b0;
      settle();
      chk({led_pwr, led_full, led_dim, led_conf, sbits[5]}, 32'h14);
   endtask

   // Detection source, thresholds at the reset value of 20 r/min, unmapped read.
   task automatic t_detect();
      wb(0, `REG_ROT_DETECT, 0); chk(rd[15:0], `ROT_DETECT_RESET);
      @(posedge clock); spd_fb <= 16'h0014; spd_cmd <= 16'h0013; trq <= 16'h000a;
      clamped <= 1'b1;
      settle(); chk({led_det, sbits[4], led_spd, led_trq}, 32'hd);
      @(posedge clock); spd_fb <= 16'h0013; spd_cmd <= 16'h0014; trq <= 16'h0009;
      settle(); chk({led_det, sbits[4], led_spd, led_trq}, 32'h2);
      wb(1, `REG_SETUP_FIRST, 32'h10); trq <= 16'hfff6;
      settle(); chk({led_det, sbits[4], led_spd, led_trq}, 32'hf);
      @(posedge clock); clamped <= 1'b0;
      settle(); chk({led_det, sbits[4]}, 32'h0);
      wb(0, 8'h1c, 0); chk(rd, 32'h0);
   endtask

   task automatic t_bits();
      wb(1, `REG_SETUP_SECOND, 32'h1); rev = 1'b1;
      pins <= 13'h1555; alarm <= 1'b1; dyn_brake_on <= 1'b1; prop <= 1'b1; clamped <= 1'b1; inv <= 1'b1;
      settle(); chk(sbits, exp_bits());
      wb(1, `REG_SETUP_SECOND, 32'h0); rev = 1'b0;
      pins <= 13'h0aaa; alarm <= 1'b0; dyn_brake_on <= 1'b0; prop <= 1'b0; clamped <= 1'b0; inv <= 1'b0;
      settle(); chk(sbits, exp_bits());
   endtask

   // Bits: alarm, forward prohibit, reverse prohibit, powered; highest first wins.
   task automatic t_symbol();
      logic [3:0] st [5] = '{4'he, 4'h6, 4'h2, 4'h0, 4'h1};
      logic [2:0] ex [5] = '{3'h4, 3'h2, 3'h3, 3'h0, 3'h1};
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clock); acode <= 8'h5a; {alarm, pins[10], pins[11], powered} <= st[i];
         settle();
         chk({sym_code, 5'h0, symbol}, {st[i][3] ? 8'h5a : 8'h00, 5'h0, ex[i]});
      end
   endtask

   task automatic t_monitor();
      logic [15:0] q [6];
      @(posedge clock); pulses <= 16'h0800; angle <= 16'h00b4; trq <= 16'h0064;
      spd_fb <= 16'h1234; spd_cmd <= 16'h2345;
      i_pu.press(0, 2); i_pu.press(0, 3); chk(mode, 32'h4);
      q = '{16'h1234, 16'h2345, 16'h0064, 16'h0800, 16'h00b4, 16'(exp_bits() >> 1)};
      for (int n = 0; n < 6; n++)
      begin
         chk(mon_num, n);
         i_pu.press(1, 2); chk(show, 1);
         wb(0, `REG_MONITOR_DATA, 0); chk(rd[15:0], q[n]);
         i_pu.press(2, 1); chk(mon_num, n);
         @(posedge clock); spd_fb <= q[n] + 16'h0001;
         settle(); wb(0, `REG_MONITOR_DATA, 0); chk(rd[15:0], n ? q[n] : 16'h1235);
         i_pu.press(1, 2); chk(show, 0);
         i_pu.press(2, 2);
      end
      chk(mon_num, 5);
      i_pu.press(0, 2); chk(mode, 32'h8);
   endtask

   // ======================================================================
   // Main sequence and watchdog.
   // ======================================================================
   initial
   begin
      {clock, rst_b, cyc, stb, we, conform, clamped, alarm, dyn_brake_on, prop, powered, inv} = '0;
      {adr, acode, wdat, spd_fb, spd_cmd, trq, pulses, angle, pins, rev} = '0;
      sel = 4'h3; err_total = 0; n_tests = 0;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      t_modes(); t_leds(); t_detect(); t_bits(); t_symbol(); t_monitor();
      tally_and_finish();
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      err_total++;
      tally_and_finish();
   end
endmodule
